// ===== rtl/fmx_pkg.sv
package fmx_pkg;
   localparam int PC_W = 11;
   localparam int PTR_W = 10;
   localparam int STK_DEPTH = 5;
   localparam int STK_PTR_W = 3;
   localparam int OP_W = 14;
   localparam int NIB_W = 4;
   localparam int RAM_AW = 10;
   localparam int RAM_WORDS = 1024;
   localparam int LCNT_W = 4;
   localparam logic [3:0] JMP_MASK = 4'h7;
   localparam logic [31:0] ADDR_STAT = 32'h00000000;
   localparam logic [31:0] ADDR_PC = 32'h00000004;
   localparam logic [31:0] ADDR_ACC = 32'h00000008;
   localparam logic [31:0] ADDR_PTRS = 32'h0000000C;
   localparam logic [31:0] ADDR_LOOP = 32'h00000010;
   localparam logic [31:0] ADDR_IMEM = 32'h00000014;
   localparam logic [31:0] ADDR_RAM = 32'h00000018;
   localparam logic [31:0] ADDR_CTRL = 32'h0000001C;
   localparam logic [31:0] ADDR_PORT = 32'h00000020;
   typedef enum logic [1:0] {
      FMX_FETCH = 2'b00,
      FMX_EXEC = 2'b01,
      FMX_WB = 2'b11
   } fmx_state_e;
endpackage

// ===== rtl/fmx_ram.sv
`timescale 1ns/1ps
module fmx_ram (
   input wire logic pclk,
   input wire logic en,
   input wire logic we,
   input wire logic [fmx_pkg::RAM_AW-1:0] waddr,
   input wire logic [fmx_pkg::NIB_W-1:0] wdata,
   input wire logic [fmx_pkg::RAM_AW-1:0] raddr,
   output logic [fmx_pkg::NIB_W-1:0] rdata
);
   logic [fmx_pkg::NIB_W-1:0] mem [fmx_pkg::RAM_WORDS];
   // No reset: contents are software-loaded, as in the real array
   always_ff @(posedge pclk) begin
      if (en) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule // fmx_ram

// ===== rtl/fmx_core.sv
`timescale 1ns/1ps
module fmx_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [3:0] key_scan_outputs,
   output logic key_scan_oe,
   input wire logic [3:0] bidir_port_in,
   output logic [3:0] bidir_port_lines,
   output logic bidir_port_oe,
   output logic clock_stopped,
   output logic cpu_halted,
   output logic divider_clear
);
   ////////////////////////////////////////////////////////////////
   logic [fmx_pkg::OP_W-1:0] op;
   logic [fmx_pkg::PC_W-1:0] pc;
   logic [fmx_pkg::PC_W-1:0] stack [fmx_pkg::STK_DEPTH];
   logic [fmx_pkg::STK_PTR_W-1:0] sp;
   logic [fmx_pkg::PTR_W-1:0] src_ptr;
   logic [fmx_pkg::PTR_W-1:0] dst_ptr;
   logic [fmx_pkg::LCNT_W-1:0] loop_cnt;
   logic [3:0] accumulator;
   logic [1:0] page;
   logic flag_z, flag_c, flag_g;
   logic run;
   logic busy;
   logic [3:0] scan_latch;
   fmx_pkg::fmx_state_e state;
   logic [3:0] rd_nib;
   logic ram_we;
   logic [fmx_pkg::RAM_AW-1:0] ram_waddr, ram_raddr;
   logic [3:0] ram_wdata;
   logic apb_go;
   logic [fmx_pkg::RAM_AW-1:0] bus_ram_addr;
   logic apb_wr;
   logic pc_hold;
   logic [fmx_pkg::PC_W-1:0] pc_prev;

   assign apb_go = psel && penable && !pready && clk_en;
   // Writes land on the completing edge, when pready is seen high
   assign apb_wr = psel && penable && pready && pwrite && clk_en;

   // Pointer step by direction bit
   function automatic logic [fmx_pkg::PTR_W-1:0] step(
      input logic [fmx_pkg::PTR_W-1:0] p, input logic down);
      step = down ? p - 10'h001 : p + 10'h001;
   endfunction

   // Relative target: direction bit picks back n or forward n+1
   function automatic logic [fmx_pkg::PC_W-1:0] rel(
      input logic [fmx_pkg::PC_W-1:0] p, input logic fwd, input logic [4:0] n);
      rel = fwd ? p + {6'h00, n} + 11'h001 : p - {6'h00, n};
   endfunction

   ////////////////////////////////////////////////////////////////
   // Operand address: paged nibble, pointer source for block ops
   logic is_ptr_op;
   assign is_ptr_op = (op[13:11] == 3'b110);
   always_comb begin
      if (!run) begin
         ram_raddr = bus_ram_addr;
      end else if (is_ptr_op) begin
         ram_raddr = src_ptr;
      end else if (op[13:10] == 4'b1111 || op[13:9] == 5'b11100) begin
         ram_raddr = op[8] ? {page, 4'h0, op[3:0]} : {2'b00, op[7:0]};
      end else begin
         ram_raddr = {page, 3'h0, op[8], op[3:0]};
      end
   end

   fmx_ram u_ram (
      .pclk(pclk),
      .en(clk_en),
      .we(ram_we),
      .waddr(ram_waddr),
      .wdata(ram_wdata),
      .raddr(ram_raddr),
      .rdata(rd_nib)
   );

   ////////////////////////////////////////////////////////////////
   // Execute decode
   logic [fmx_pkg::PC_W-1:0] next_pc;
   logic [3:0] next_acc;
   logic next_z, next_c, next_g;
   logic do_wb;
   logic [3:0] wb_val;
   logic push, pop;
   logic [fmx_pkg::PTR_W-1:0] next_src, next_dst;
   logic [fmx_pkg::LCNT_W-1:0] next_loop;
   logic [4:0] sum;
   logic take;
   logic done;
   logic [fmx_pkg::LCNT_W-1:0] dec_l;

   always_comb begin
      next_pc = pc + 11'h001;
      next_acc = accumulator;
      next_z = flag_z;
      next_c = flag_c;
      next_g = flag_g;
      do_wb = 1'b0;
      wb_val = rd_nib;
      push = 1'b0;
      pop = 1'b0;
      next_src = src_ptr;
      next_dst = dst_ptr;
      next_loop = loop_cnt;
      sum = 5'h00;
      take = 1'b0;
      done = 1'b1;
      dec_l = loop_cnt - 4'h1;
      if (op[13:12] == 2'b01) begin
         unique case (op[11:9])
            3'b000: sum = {1'b0, rd_nib | op[7:4]};
            3'b001: sum = {1'b0, rd_nib & ~op[7:4]};
            3'b010: sum = {1'b0, rd_nib & op[7:4]};
            3'b011: sum = {1'b0, rd_nib} - {1'b0, op[7:4]};
            3'b100: sum = {1'b0, rd_nib} + {1'b0, op[7:4]};
            3'b101: sum = {1'b0, rd_nib} - {1'b0, op[7:4]};
            3'b110: sum = {1'b0, op[7:4]};
            3'b111: sum = {1'b0, rd_nib ^ op[7:4]};
         endcase
         next_z = (sum[3:0] == 4'h0);
         next_c = sum[4];
         next_g = (rd_nib > op[7:4]);
         // Test and compare forms only touch the flags
         do_wb = (op[11:9] != 3'b010) && (op[11:9] != 3'b011);
         wb_val = sum[3:0];
      end else if (op[13:10] == 4'b0000 && op[8:6] == 3'b010 && op[3:0] == 4'h0) begin
         if (op[5:4] == 2'b11) begin
            next_z = op[9];
            next_c = op[9];
            next_g = op[9];
         end else if (op[5:4] == 2'b10) begin
            next_z = op[9];
         end else if (op[5:4] == 2'b01) begin
            next_c = op[9];
         end else begin
            next_g = op[9];
         end
      end else if (op[13:10] == 4'b0000 && op[7:4] == 4'b1101) begin
         next_pc = pc + {7'h00, op[9] ? (rd_nib & fmx_pkg::JMP_MASK) : rd_nib} + 11'h001;
      end else if (op[13:10] == 4'b0000 && op[7:4] == 4'b1100) begin
         pop = 1'b1;
         next_pc = stack[sp - 3'h1] + 11'h001;
      end else if (op[13:11] == 3'b101) begin
         push = 1'b1;
         next_pc = op[10:0];
      end else if (op[13:11] == 3'b100) begin
         next_pc = op[10:0];
      end else if (op[13:9] == 5'b11101) begin
         unique case (op[6:5])
            2'b10: take = flag_z;
            2'b00: take = flag_c;
            2'b01: take = flag_g;
            2'b11: take = flag_g || flag_z;
         endcase
         if (op[7]) begin
            take = !take;
         end
         if (take) begin
            next_pc = rel(pc, op[8], op[4:0]);
         end
      end else if (is_ptr_op) begin
         if (!op[10]) begin
            next_acc = rd_nib;
         end
         if (op[9]) begin
            next_loop = dec_l;
         end
         if (op[6]) begin
            done = (rd_nib == 4'h0);
         end else if (op[7]) begin
            done = (rd_nib != 4'h0);
         end else begin
            done = 1'b0;
         end
         done = done || (op[9] && dec_l == 4'h0);
         if (op[9] || op[7:6] != 2'b00) begin
            // Repeating form: skip when done, else step and rerun
            if (done) begin
               next_pc = pc + 11'h002;
            end else begin
               next_src = step(src_ptr, op[4]);
               next_dst = op[10] ? step(dst_ptr, op[4]) : dst_ptr;
               next_pc = pc;
            end
         end else if (op[5]) begin
            next_src = step(src_ptr, op[4]);
            next_dst = op[10] ? step(dst_ptr, op[4]) : dst_ptr;
         end
      end else if (op[13:9] == 5'b11111) begin
         next_acc = rd_nib;
      end else if (op[13:10] == 4'b1110) begin
         next_acc = rd_nib;
         do_wb = 1'b1;
         wb_val = accumulator;
      end else if (op[13:9] == 5'b11110) begin
         do_wb = 1'b1;
         wb_val = accumulator;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Write port: exec writeback, pointer move, or bus access
   always_comb begin
      ram_we = 1'b0;
      ram_waddr = ram_raddr;
      ram_wdata = wb_val;
      if (!run) begin
         ram_we = apb_wr && paddr == fmx_pkg::ADDR_RAM;
         ram_waddr = bus_ram_addr;
         ram_wdata = pwdata[3:0];
      end else if (state == fmx_pkg::FMX_EXEC && is_ptr_op && op[10]) begin
         ram_we = 1'b1;
         ram_waddr = dst_ptr;
         ram_wdata = rd_nib;
      end else if (state == fmx_pkg::FMX_EXEC) begin
         ram_we = do_wb;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Sequencer: fetch (RAM read settles), exec, writeback
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= fmx_pkg::FMX_FETCH;
      end else if (clk_en) begin
         unique case (state)
            fmx_pkg::FMX_FETCH: state <= run ? fmx_pkg::FMX_EXEC : fmx_pkg::FMX_FETCH;
            fmx_pkg::FMX_EXEC: state <= fmx_pkg::FMX_WB;
            fmx_pkg::FMX_WB: state <= fmx_pkg::FMX_FETCH;
            default: state <= fmx_pkg::FMX_FETCH;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc <= '0;
         accumulator <= 4'h0;
         flag_z <= 1'b0;
         flag_c <= 1'b0;
         flag_g <= 1'b0;
         src_ptr <= '0;
         dst_ptr <= '0;
         loop_cnt <= '0;
         sp <= '0;
         busy <= 1'b0;
         for (int i = 0; i < fmx_pkg::STK_DEPTH; i++) begin
            stack[i] <= '0;
         end
      end else if (clk_en) begin
         busy <= run && state != fmx_pkg::FMX_FETCH;
         if (run && state == fmx_pkg::FMX_EXEC) begin
            pc <= next_pc;
            accumulator <= next_acc;
            flag_z <= next_z;
            flag_c <= next_c;
            flag_g <= next_g;
            src_ptr <= next_src;
            dst_ptr <= next_dst;
            loop_cnt <= next_loop;
            if (push && sp < 3'(fmx_pkg::STK_DEPTH)) begin
               stack[sp] <= pc;
               sp <= sp + 3'h1;
            end else if (pop && sp != 3'h0) begin
               sp <= sp - 3'h1;
            end
         end else if (!run && apb_wr) begin
            if (paddr == fmx_pkg::ADDR_PC) begin
               pc <= pwdata[10:0];
            end
            if (paddr == fmx_pkg::ADDR_ACC) begin
               accumulator <= pwdata[3:0];
            end
            if (paddr == fmx_pkg::ADDR_PTRS) begin
               src_ptr <= pwdata[9:0];
               dst_ptr <= pwdata[25:16];
            end
            if (paddr == fmx_pkg::ADDR_LOOP) begin
               loop_cnt <= pwdata[3:0];
            end
         end
      end
   end

   // Port and CPU control instructions, plus software run control
   logic ctl_op;
   assign ctl_op = run && state == fmx_pkg::FMX_EXEC && op[13:8] == 6'b001110;
   logic scan_off;
   assign scan_off = ctl_op && op[7:0] == 8'h74;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op <= '0;
         page <= 2'b00;
         run <= 1'b0;
         key_scan_oe <= 1'b0;
         bidir_port_oe <= 1'b0;
         clock_stopped <= 1'b0;
         cpu_halted <= 1'b0;
         divider_clear <= 1'b0;
         scan_latch <= 4'h0;
      end else if (clk_en) begin
         divider_clear <= 1'b0;
         if (ctl_op) begin
            unique case (op[7:0])
               8'h78: key_scan_oe <= 1'b1;
               8'h74: key_scan_oe <= 1'b0;
               8'h72: bidir_port_oe <= 1'b1;
               8'h71: bidir_port_oe <= 1'b0;
               8'h00: clock_stopped <= 1'b1;
               8'h10: cpu_halted <= 1'b1;
               8'h20: cpu_halted <= 1'b0;
               8'h90: divider_clear <= 1'b1;
               default: divider_clear <= 1'b0;
            endcase
            // Halt or stop hands control back to software
            if (op[7:0] == 8'h00 || op[7:0] == 8'h10) begin
               run <= 1'b0;
            end
         end else if (!run && apb_wr) begin
            if (paddr == fmx_pkg::ADDR_IMEM) begin
               op <= pwdata[13:0];
            end
            if (paddr == fmx_pkg::ADDR_CTRL) begin
               run <= pwdata[0];
               page <= pwdata[5:4];
               clock_stopped <= 1'b0;
               cpu_halted <= 1'b0;
            end
            if (paddr == fmx_pkg::ADDR_PORT) begin
               scan_latch <= pwdata[3:0];
            end
         end else if (run && state == fmx_pkg::FMX_WB) begin
            // One instruction per go; repeating block ops keep running unless pc is 7FF
            run <= (pc == 11'h7FF) ? 1'b0 : (op[13:11] == 3'b110 && busy && pc_hold);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_prev <= '0;
      end else if (clk_en && run && state == fmx_pkg::FMX_EXEC) begin
         pc_prev <= pc;
      end
   end
   assign pc_hold = (pc_prev == pc);

   // Scan port drives only while its enable is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_scan_outputs <= 4'h0;
         bidir_port_lines <= 4'h0;
      end else if (clk_en) begin
         // gated drive
         // Disable drops the lines on the same edge as the enable
         key_scan_outputs <= (key_scan_oe && !scan_off) ? scan_latch : 4'h0;
         bidir_port_lines <= accumulator;
      end
   end

   ////////////////////////////////////////////////////////////////
   // APB slave, one wait state
   assign bus_ram_addr = src_ptr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         pready <= apb_go;
         pslverr <= 1'b0;
         if (apb_go) begin
            pslverr <= paddr > fmx_pkg::ADDR_PORT || paddr[1:0] != 2'b00;
            unique case (paddr)
               fmx_pkg::ADDR_STAT: prdata <= {26'h0, cpu_halted, clock_stopped,
                  flag_g, flag_c, flag_z, run};
               fmx_pkg::ADDR_PC: prdata <= {21'h0, pc};
               fmx_pkg::ADDR_ACC: prdata <= {28'h0, accumulator};
               fmx_pkg::ADDR_PTRS: prdata <= {6'h0, dst_ptr, 6'h0, src_ptr};
               fmx_pkg::ADDR_LOOP: prdata <= {25'h0, sp, loop_cnt};
               fmx_pkg::ADDR_IMEM: prdata <= {18'h0, op};
               fmx_pkg::ADDR_RAM: prdata <= {28'h0, rd_nib};
               fmx_pkg::ADDR_CTRL: prdata <= {26'h0, page, 3'h0, run};
               fmx_pkg::ADDR_PORT: prdata <= {22'h0, bidir_port_oe, key_scan_oe,
                  bidir_port_in, scan_latch};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // fmx_core

// ===== tb/fmx_core_sva.sv
`timescale 1ns/1ps
module fmx_core_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] key_scan_outputs,
   input wire logic key_scan_oe,
   input wire logic clock_stopped,
   input wire logic divider_clear
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   // One wait state, so software timing is fixed
   pready_wait_a: assert property ($rose(psel && penable) && clk_en |=> pready)
      else $error("pready not one cycle after access");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready wider than one cycle");
   pready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("pready without access");
   slverr_pair_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   slverr_addr_a: assert property (pready && psel
      |-> pslverr == (paddr > 32'h20 || paddr[1:0] != 2'h0))
      else $error("pslverr wrong for address");
   prdata_hold_a: assert property (!pready |-> $stable(prdata))
      else $error("prdata moved outside answer");
   scan_gate_a: assert property (!key_scan_oe |-> key_scan_outputs == 4'h0)
      else $error("scan lines driven while disabled");
   divider_pulse_a: assert property (divider_clear |=> !divider_clear)
      else $error("divider clear wider than one cycle");
   stop_hold_a: assert property (clock_stopped |=> clock_stopped)
      else $error("stopped clock restarted without reset");
endmodule // fmx_core_sva

bind fmx_core fmx_core_sva u_sva (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .key_scan_outputs(key_scan_outputs), .key_scan_oe(key_scan_oe),
   .clock_stopped(clock_stopped), .divider_clear(divider_clear));

// ===== tb/fmx_port_model.sv
`timescale 1ns/1ps
module fmx_port_model (
   input wire logic pclk,
   input wire logic [3:0] bidir_port_lines,
   input wire logic bidir_port_oe,
   output logic [3:0] bidir_port_in
);
   logic [3:0] idle_pat = 4'h5;
   // No pull on these lines: a stale level must not pass
   always @(posedge pclk) idle_pat <= ~idle_pat;
   // wire follows device in output mode
   assign bidir_port_in = bidir_port_oe ? bidir_port_lines : idle_pat;
endmodule // fmx_port_model

// ===== tb/fmx_core_tb.sv
`timescale 1ns/1ps
module fmx_core_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, key_scan_oe, bidir_port_oe;
   logic [3:0] key_scan_outputs, bidir_port_lines, bidir_port_in;
   logic clock_stopped, cpu_halted, divider_clear;
   logic [31:0] rd;
   logic err;
   int bad_count = 0;
   int total_checks = 0;
   int div_pulses = 0;

   always #20 pclk = ~pclk;
   always @(posedge pclk) if (divider_clear === 1'b1) div_pulses++;

   fmx_core DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .key_scan_outputs(key_scan_outputs), .key_scan_oe(key_scan_oe),
      .bidir_port_in(bidir_port_in), .bidir_port_lines(bidir_port_lines),
      .bidir_port_oe(bidir_port_oe), .clock_stopped(clock_stopped),
      .cpu_halted(cpu_halted), .divider_clear(divider_clear));
   fmx_port_model u_port (.pclk(pclk), .bidir_port_lines(bidir_port_lines),
      .bidir_port_oe(bidir_port_oe), .bidir_port_in(bidir_port_in));
   ////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask

   // Software must wait for run to drop before touching state
   task automatic exec(input logic [13:0] op);
      int n;
      n = 0;
      apb(1'b1, fmx_pkg::ADDR_IMEM, {18'h0, op});
      apb(1'b1, fmx_pkg::ADDR_CTRL, 32'h1);
      do begin
         apb(1'b0, fmx_pkg::ADDR_STAT, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 100);
      if (n >= 100) bad_count++;
   endtask

   task automatic fill(input logic [9:0] b, input logic [15:0] v);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, fmx_pkg::ADDR_PTRS, {22'h0, b + 10'(i)});
         apb(1'b1, fmx_pkg::ADDR_RAM, {28'h0, v[4*i+:4]});
      end
   endtask

   function automatic logic taken(input int c, input int f);
      logic b;
      case (c % 4)
         0: b = f[1];
         1: b = f[2];
         2: b = f[0];
         default: b = f[2] | f[0];
      endcase
      return b ^ c[2];
   endfunction

   task automatic do_reset;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge pclk);
      bad_count++;
      end_sim();
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(fmx_pkg::ADDR_PC, 32'h0, 32'h7FF);
      apb(1'b0, 32'h24, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 32'h2, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, fmx_pkg::ADDR_PC, 32'h123);
      exec(14'h2DA5);
      rdchk(fmx_pkg::ADDR_PC, 32'h5A5, 32'h7FF);
      rdchk(fmx_pkg::ADDR_LOOP, 32'h10, 32'h70);
      exec(14'h02B0);
      rdchk(fmx_pkg::ADDR_STAT, 32'hE, 32'hE);
      exec(14'h00B0);
      rdchk(fmx_pkg::ADDR_STAT, 32'h0, 32'hE);
      // Every flag mix against every condition code
      for (int f = 0; f < 8; f++) begin
         exec(14'h00B0);
         if (f[0]) exec(14'h02A0);
         if (f[1]) exec(14'h0290);
         if (f[2]) exec(14'h0280);
         rdchk(fmx_pkg::ADDR_STAT, 32'(f << 1), 32'hE);
         for (int c = 0; c < 8; c++) begin
            apb(1'b1, fmx_pkg::ADDR_PC, 32'h100);
            exec(14'h3B03 | 14'(c << 5));
            rdchk(fmx_pkg::ADDR_PC, taken(c, f) ? 32'h104 : 32'h101, 32'h7FF);
         end
      end
      apb(1'b1, fmx_pkg::ADDR_PC, 32'h100);
      exec(14'h3A45);
      rdchk(fmx_pkg::ADDR_PC, 32'hFB, 32'h7FF);
      fill(10'h5, 16'h000F);
      apb(1'b1, fmx_pkg::ADDR_PTRS, 32'h5);
      apb(1'b1, fmx_pkg::ADDR_PC, 32'h200);
      exec(14'h00D5);
      rdchk(fmx_pkg::ADDR_PC, 32'h210, 32'h7FF);
      apb(1'b1, fmx_pkg::ADDR_PC, 32'h200);
      exec(14'h02D5);
      rdchk(fmx_pkg::ADDR_PC, 32'h208, 32'h7FF);
      apb(1'b1, fmx_pkg::ADDR_RAM, 32'hB);
      exec(14'h1235);
      rdchk(fmx_pkg::ADDR_RAM, 32'h8, 32'hF);
      exec(14'h3020);
      rdchk(fmx_pkg::ADDR_ACC, 32'h8, 32'hF);
      rdchk(fmx_pkg::ADDR_PTRS, 32'h6, 32'h3FF);
      exec(14'h3030);
      rdchk(fmx_pkg::ADDR_PTRS, 32'h5, 32'h3FF);
      fill(10'h10, 16'h7023);
      apb(1'b1, fmx_pkg::ADDR_PTRS, 32'h10);
      apb(1'b1, fmx_pkg::ADDR_PC, 32'h300);
      exec(14'h3040);
      rdchk(fmx_pkg::ADDR_ACC, 32'h0, 32'hF);
      rdchk(fmx_pkg::ADDR_PTRS, 32'h12, 32'h3FF);
      rdchk(fmx_pkg::ADDR_PC, 32'h302, 32'h7FF);
      fill(10'h20, 16'h1900);
      apb(1'b1, fmx_pkg::ADDR_PTRS, 32'h20);
      apb(1'b1, fmx_pkg::ADDR_PC, 32'h300);
      exec(14'h3080);
      rdchk(fmx_pkg::ADDR_ACC, 32'h9, 32'hF);
      rdchk(fmx_pkg::ADDR_PTRS, 32'h22, 32'h3FF);
      rdchk(fmx_pkg::ADDR_PC, 32'h302, 32'h7FF);
      fill(10'h30, 16'h1111);
      apb(1'b1, fmx_pkg::ADDR_PTRS, 32'h30);
      apb(1'b1, fmx_pkg::ADDR_LOOP, 32'h12);
      apb(1'b1, fmx_pkg::ADDR_PC, 32'h300);
      exec(14'h3240);
      rdchk(fmx_pkg::ADDR_LOOP, 32'h0, 32'hF);
      rdchk(fmx_pkg::ADDR_PTRS, 32'h31, 32'h3FF);
      rdchk(fmx_pkg::ADDR_PC, 32'h302, 32'h7FF);
      fill(10'h40, 16'h4321);
      apb(1'b1, fmx_pkg::ADDR_PTRS, 32'h00500040);
      apb(1'b1, fmx_pkg::ADDR_LOOP, 32'h13);
      apb(1'b1, fmx_pkg::ADDR_PC, 32'h300);
      exec(14'h3600);
      rdchk(fmx_pkg::ADDR_PTRS, 32'h00520042, 32'h03FF03FF);
      rdchk(fmx_pkg::ADDR_PC, 32'h302, 32'h7FF);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, fmx_pkg::ADDR_PTRS, 32'h50 + 32'(i));
         rdchk(fmx_pkg::ADDR_RAM, 32'(i + 1), 32'hF);
      end
      apb(1'b1, fmx_pkg::ADDR_PORT, 32'hA);
      chk(32'({key_scan_oe, key_scan_outputs}), 32'h0);
      exec(14'h0E78);
      chk(32'({key_scan_oe, key_scan_outputs}), 32'h1A);
      exec(14'h0E74);
      chk(32'({key_scan_oe, key_scan_outputs}), 32'h0);
      apb(1'b1, fmx_pkg::ADDR_ACC, 32'h5);
      exec(14'h0E72);
      chk(32'({bidir_port_oe, bidir_port_lines}), 32'h15);
      rdchk(fmx_pkg::ADDR_PORT, 32'h25A, 32'h3FF);
      exec(14'h0E71);
      chk(32'(bidir_port_oe), 32'h0);
      exec(14'h0E90);
      chk(32'(div_pulses), 32'h1);
      exec(14'h0E10);
      chk(32'(cpu_halted), 32'h1);
      do_reset();
      chk(32'(cpu_halted), 32'h0);
      exec(14'h0E00);
      chk(32'(clock_stopped), 32'h1);
      end_sim();
   end
endmodule // fmx_core_tb
